/* File: src/can_diag_session_commands.sv */
// command interpreter for per-channel diagnostic sessions: start, buffer query, stop, state query
// assumes one command header per beat, response bytes drained over a valid/ready stream
`timescale 1ns/10ps
`default_nettype none
module can_diag_session_commands
    import can_diag_pkg::*;
#(
    parameter int NCH = 2,
    parameter int DEPTH = 64,
    parameter logic [15:0] MAX_PARAM_BYTES = 16'h0040
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // command header from the host
    input wire logic cmd_valid_in,
    input wire diag_cmd_t cmd_in,
    output logic cmd_ready_out,
    // response byte stream to the host
    output logic rsp_valid_out,
    output logic [7:0] rsp_byte_out,
    output logic rsp_last_out,
    input wire logic rsp_ready_in,
    // session environment
    input wire logic [NCH-1:0] chan_alloc_in,
    input wire logic [7:0] diag_type_in,
    input wire logic [NCH-1:0] link_up_in,
    input wire logic [NCH-1:0] link_down_in,
    // fault reports from the protocol engine
    input wire logic fault_valid_in,
    input wire logic [7:0] fault_chan_in,
    input wire logic [7:0] fault_code_in,
    // received response bytes
    input wire logic rx_valid_in,
    input wire rx_beat_t rx_in,
    // closing request to the transmit side
    output logic req_start_out,
    output close_req_t req_out
);
    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam int PW = $clog2(DEPTH);
    localparam int NW = $clog2(DEPTH + 1);
    localparam logic [15:0] MAX_PAY = MAX_PARAM_BYTES - HDR_LEN;

    function automatic logic chan_ok(input logic [7:0] ch);
        chan_ok = (ch < 8'(NCH));
    endfunction

    function automatic logic known_code(input logic [7:0] c);
        known_code = (c == CMD_START) || (c == CMD_QUERY) || (c == CMD_STOP) || (c == CMD_STATE);
    endfunction

    rsp_fsm_t fsm, next_fsm;
    logic [7:0] hdr [8];
    logic [7:0] next_hdr [8];
    logic [15:0] total, next_total, idx, next_idx;
    logic [CW-1:0] rch, next_rch;
    logic [7:0] code_q, next_code;
    diag_state_t dstate [NCH];
    diag_state_t next_dstate [NCH];
    logic [7:0] fault [NCH];
    logic [7:0] next_fault [NCH];
    logic [NCH-1:0] busy, next_busy, seg, next_seg, inc, dec;
    logic [PW-1:0] wptr [NCH];
    logic [PW-1:0] next_wptr [NCH];
    logic [PW-1:0] rptr [NCH];
    logic [PW-1:0] next_rptr [NCH];
    logic [NW-1:0] cnt [NCH];
    logic [NW-1:0] next_cnt [NCH];
    logic [7:0] store [NCH][DEPTH];
    logic [7:0] next_store [NCH][DEPTH];
    logic next_cmd_ready, next_rsp_valid, next_rsp_last, next_req_start;
    logic [7:0] next_rsp_byte;
    close_req_t next_req;
    logic [CW-1:0] cch, xch;
    logic cmd_take, cmd_ok, rx_take;
    logic [7:0] sel_fault;
    logic [NW-1:0] sel_cnt;
    diag_state_t sel_state;
    logic [15:0] pay_len, rem_len;

    // addressed channel views, shared by the decode and the checks
    assign cch = cmd_in.channel[CW-1:0];
    assign xch = rx_in.channel[CW-1:0];
    assign cmd_take = (fsm == RSP_IDLE) && cmd_valid_in && known_code(cmd_in.code);
    assign cmd_ok = chan_ok(cmd_in.channel) && chan_alloc_in[cch];
    assign rx_take = rx_valid_in && chan_ok(rx_in.channel) && busy[xch] && (cnt[xch] < NW'(DEPTH));
    assign sel_fault = fault[cch];
    assign sel_cnt = cnt[cch];
    assign sel_state = dstate[cch];
    // payload capped at parameter size less header
    assign pay_len = (16'(sel_cnt) < MAX_PAY) ? 16'(sel_cnt) : MAX_PAY;
    assign rem_len = 16'(sel_cnt) - pay_len;

    // next-state logic for sessions, buffers and the response sequencer
    always_comb begin
        next_fsm = fsm;
        next_hdr = hdr;
        next_total = total;
        next_idx = idx;
        next_rch = rch;
        next_code = code_q;
        next_dstate = dstate;
        next_fault = fault;
        next_busy = busy;
        next_seg = seg;
        next_wptr = wptr;
        next_rptr = rptr;
        next_store = store;
        next_cnt = cnt;
        next_req = req_out;
        next_req_start = 1'b0;
        next_rsp_valid = rsp_valid_out;
        next_rsp_byte = rsp_byte_out;
        next_rsp_last = rsp_last_out;
        inc = '0;
        dec = '0;
        // link progress moves the connection state
        for (int c = 0; c < NCH; c++) begin
            if (link_up_in[c] && dstate[c] == ST_ESTABLISHING) begin
                next_dstate[c] = ST_ESTABLISHED;
            end
            if (link_down_in[c] && dstate[c] == ST_RELEASING) begin
                next_dstate[c] = ST_NO_CONN;
            end
        end
        // expected bytes only; final byte ends busy
        if (rx_take) begin
            next_store[xch][wptr[xch]] = rx_in.data;
            next_wptr[xch] = wptr[xch] + PW'(1);
            next_seg[xch] = rx_in.seg;
            inc[xch] = 1'b1;
            if (rx_in.last) begin
                next_busy[xch] = 1'b0;
            end
        end
        // command decode: header latched so the reply reflects pre-command values
        if (cmd_take) begin
            next_fsm = RSP_SEND;
            next_idx = 16'h0000;
            next_rch = cch;
            next_code = cmd_in.code;
            next_total = ACK_LEN;
            for (int b = 0; b < 8; b++) begin
                next_hdr[b] = 8'h00;
            end
            next_hdr[B_CHAN] = cmd_in.channel;
            next_hdr[B_FAULT] = cmd_ok ? sel_fault : FAULT_NO_SESSION;
            unique case (cmd_in.code)
                CMD_QUERY: begin
                    next_total = HDR_LEN + (cmd_ok ? pay_len : 16'h0000);
                    if (cmd_ok) begin
                        next_hdr[B_FLAGS][FLAG_SEG] = seg[cch];
                        next_hdr[B_FLAGS][FLAG_BUSY] = busy[cch];
                        next_hdr[B_FLAGS][FLAG_VALID] = (sel_cnt != '0);
                        next_hdr[B_FLAGS][FLAG_MORE] = (rem_len != 16'h0000);
                        next_hdr[B_STATE] = {5'h00, sel_state};
                        next_hdr[B_LEN_LO] = pay_len[7:0];
                        next_hdr[B_LEN_HI] = pay_len[15:8];
                        next_hdr[B_REM_LO] = rem_len[7:0];
                        next_hdr[B_REM_HI] = rem_len[15:8];
                    end
                end
                CMD_STOP: begin
                    if (cmd_ok) begin
                        next_dstate[cch] = ST_RELEASING;
                        if (cmd_in.length != 16'h0000) begin
                            next_fault[cch] = FAULT_NONE;
                            next_busy[cch] = 1'b1;
                            next_req_start = 1'b1;
                            next_req.channel = cmd_in.channel;
                            next_req.mode = cmd_in.mode;
                            next_req.length = cmd_in.length;
                            next_req.no_rsp = cmd_in.mode[MODE_NO_RSP_BIT];
                        end
                    end
                end
                CMD_STATE: begin
                    next_total = HDR_LEN;
                    if (cmd_ok) begin
                        // report the value held before clearing
                        next_hdr[S_TYPE] = diag_type_in;
                        next_hdr[S_STATE] = {5'h00, sel_state};
                        next_hdr[S_FLAGS][SFLAG_BUSY] = busy[cch];
                        next_hdr[S_FLAGS][SFLAG_MORE] = (sel_cnt != '0);
                        if (cmd_in.mode == CLEAR_FAULT) begin
                            next_fault[cch] = FAULT_NONE;
                        end
                    end
                end
                CMD_START: begin
                    if (cmd_ok) begin
                        next_fault[cch] = FAULT_NONE;
                        next_dstate[cch] = ST_ESTABLISHING;
                    end
                end
            endcase
        end
        // a fresh fault wins over any clear in the same cycle
        if (fault_valid_in && chan_ok(fault_chan_in)) begin
            next_fault[fault_chan_in[CW-1:0]] = fault_code_in;
        end
        // header bytes then payload popped from the buffer
        if (fsm == RSP_SEND && (!rsp_valid_out || rsp_ready_in)) begin
            next_rsp_valid = 1'b1;
            next_rsp_last = (idx == total - 16'h0001);
            next_idx = idx + 16'h0001;
            if (idx < HDR_LEN) begin
                next_rsp_byte = hdr[idx[2:0]];
            end else begin
                // unread bytes stay for the next query
                next_rsp_byte = store[rch][rptr[rch]];
                next_rptr[rch] = rptr[rch] + PW'(1);
                dec[rch] = 1'b1;
            end
            if (idx == total - 16'h0001) begin
                next_fsm = RSP_IDLE;
            end
        end else if (rsp_ready_in) begin
            next_rsp_valid = 1'b0;
            next_rsp_last = 1'b0;
        end
        for (int c = 0; c < NCH; c++) begin
            next_cnt[c] = cnt[c] + NW'(inc[c]) - NW'(dec[c]);
        end
        next_cmd_ready = (next_fsm == RSP_IDLE);
    end

    // registers only; synchronous active-low reset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            fsm <= RSP_IDLE;
            total <= 16'h0000;
            idx <= 16'h0000;
            rch <= '0;
            code_q <= 8'h00;
            busy <= '0;
            seg <= '0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_byte_out <= 8'h00;
            rsp_last_out <= 1'b0;
            req_start_out <= 1'b0;
            req_out <= '0;
            for (int b = 0; b < 8; b++) begin
                hdr[b] <= 8'h00;
            end
            for (int c = 0; c < NCH; c++) begin
                dstate[c] <= ST_NOT_INIT;
                fault[c] <= FAULT_NONE;
                wptr[c] <= '0;
                rptr[c] <= '0;
                cnt[c] <= '0;
                for (int d = 0; d < DEPTH; d++) begin
                    store[c][d] <= 8'h00;
                end
            end
        end else begin
            fsm <= next_fsm;
            hdr <= next_hdr;
            total <= next_total;
            idx <= next_idx;
            rch <= next_rch;
            code_q <= next_code;
            dstate <= next_dstate;
            fault <= next_fault;
            busy <= next_busy;
            seg <= next_seg;
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
            store <= next_store;
            cmd_ready_out <= next_cmd_ready;
            rsp_valid_out <= next_rsp_valid;
            rsp_byte_out <= next_rsp_byte;
            rsp_last_out <= next_rsp_last;
            req_start_out <= next_req_start;
            req_out <= next_req;
        end
    end

    // checks on the decode and the response stream
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_echo_channel;
        (cmd_take && rsp_ready_in) ##1 rsp_ready_in |=> rsp_valid_out && rsp_byte_out == $past(cmd_in.channel, 2);
    endproperty
    a_echo_channel: assert property (p_echo_channel) else $error("channel not echoed in byte 0");
    property p_reserved_flags;
        rsp_valid_out && code_q == CMD_QUERY && idx == 16'h0003 |-> rsp_byte_out[7:4] == 4'h0;
    endproperty
    a_reserved_flags: assert property (p_reserved_flags) else $error("reserved flag bits set");
    property p_unalloc;
        cmd_take && !cmd_ok |=> hdr[B_FAULT] == FAULT_NO_SESSION && hdr[B_FLAGS] == 8'h00 && dstate[rch] == $past(dstate[cch]);
    endproperty
    a_unalloc: assert property (p_unalloc) else $error("unallocated channel not refused");
    property p_fault_before_clear;
        cmd_take && cmd_ok && cmd_in.code == CMD_STATE |=> hdr[B_FAULT] == $past(sel_fault);
    endproperty
    a_fault_before_clear: assert property (p_fault_before_clear) else $error("state query fault wrong");
    property p_clear_fault;
        cmd_take && cmd_ok && cmd_in.code == CMD_STATE && cmd_in.mode == CLEAR_FAULT && !fault_valid_in
            |=> fault[rch] == FAULT_NONE;
    endproperty
    a_clear_fault: assert property (p_clear_fault) else $error("fault not cleared on request");
    property p_stop_request;
        cmd_take && cmd_ok && cmd_in.code == CMD_STOP && cmd_in.length != 16'h0000 && !fault_valid_in
            |=> fault[rch] == FAULT_NONE && req_start_out && req_out.no_rsp == $past(cmd_in.mode[MODE_NO_RSP_BIT]);
    endproperty
    a_stop_request: assert property (p_stop_request) else $error("stop with request mishandled");
    property p_no_empty_request;
        cmd_take && cmd_in.code == CMD_STOP && cmd_in.length == 16'h0000 |=> !req_start_out;
    endproperty
    a_no_empty_request: assert property (p_no_empty_request) else $error("request sent for zero length");
    property p_stop_release;
        cmd_take && cmd_ok && cmd_in.code == CMD_STOP |=> dstate[rch] == ST_RELEASING;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop did not release");
    property p_len_cap;
        cmd_take && cmd_in.code == CMD_QUERY |=> total <= HDR_LEN + MAX_PAY;
    endproperty
    a_len_cap: assert property (p_len_cap) else $error("payload above cap");
    property p_remaining;
        cmd_take && cmd_ok && cmd_in.code == CMD_QUERY
            |=> 16'({hdr[B_REM_HI], hdr[B_REM_LO]} + {hdr[B_LEN_HI], hdr[B_LEN_LO]}) == 16'($past(sel_cnt));
    endproperty
    a_remaining: assert property (p_remaining) else $error("remaining count wrong");
    property p_state_code;
        cmd_take && cmd_ok && cmd_in.code == CMD_QUERY |=> hdr[B_STATE] == {5'h00, $past(sel_state)};
    endproperty
    a_state_code: assert property (p_state_code) else $error("state byte wrong");
    property p_busy_end;
        rx_take && rx_in.last && !(cmd_take && cmd_in.code == CMD_STOP) |=> !busy[$past(xch)];
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy not cleared at end");

    c_query_payload: cover property (rsp_valid_out && rsp_last_out && code_q == CMD_QUERY && total > HDR_LEN);
    c_state_clear: cover property (cmd_take && cmd_in.code == CMD_STATE && cmd_in.mode == CLEAR_FAULT);
    c_unalloc_query: cover property (cmd_take && !cmd_ok && cmd_in.code == CMD_QUERY);
    c_stop_req: cover property (req_start_out);
endmodule
`default_nettype wire

/* File: src/can_diag_pkg.sv */
// constants and types for the per-channel diagnostic session command block
// assumes byte commands arrive already framed as one header beat per command
package can_diag_pkg;
    // command codes
    localparam logic [7:0] CMD_START = 8'hA1;
    localparam logic [7:0] CMD_QUERY = 8'hA3;
    localparam logic [7:0] CMD_STOP = 8'hA4;
    localparam logic [7:0] CMD_STATE = 8'hA5;
    // response lengths in bytes
    localparam logic [15:0] HDR_LEN = 16'h0008;
    localparam logic [15:0] ACK_LEN = 16'h0002;
    // byte positions of the buffer query response
    localparam int B_CHAN = 0;
    localparam int B_FAULT = 1;
    localparam int B_FLAGS = 2;
    localparam int B_STATE = 3;
    localparam int B_LEN_LO = 4;
    localparam int B_LEN_HI = 5;
    localparam int B_REM_LO = 6;
    localparam int B_REM_HI = 7;
    // byte positions of the state query response
    localparam int S_TYPE = 2;
    localparam int S_STATE = 3;
    localparam int S_FLAGS = 4;
    // flag bits of the buffer query response
    localparam int FLAG_SEG = 0;
    localparam int FLAG_BUSY = 1;
    localparam int FLAG_VALID = 2;
    localparam int FLAG_MORE = 3;
    // flag bits of the state query response
    localparam int SFLAG_BUSY = 0;
    localparam int SFLAG_MORE = 1;
    // mode byte: bit 0 functional addressing, top bit no answer needed
    localparam int MODE_NO_RSP_BIT = 7;
    localparam logic [7:0] CLEAR_FAULT = 8'h01;
    // fault codes
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_NO_SESSION = 8'h01;
    // session state as reported to the host
    typedef enum logic [2:0] {
        ST_NOT_INIT = 3'b000,
        ST_NO_CONN = 3'b001,
        ST_ESTABLISHING = 3'b010,
        ST_ESTABLISHED = 3'b011,
        ST_RELEASING = 3'b100
    } diag_state_t;
    typedef enum logic [0:0] {
        RSP_IDLE = 1'b0,
        RSP_SEND = 1'b1
    } rsp_fsm_t;
    // command header: code, bytes 0 and 1, bytes 2..3 as length
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] channel;
        logic [7:0] mode;
        logic [15:0] length;
    } diag_cmd_t;
    // one received response byte from the link side
    typedef struct packed {
        logic [7:0] channel;
        logic [7:0] data;
        logic seg;
        logic last;
    } rx_beat_t;
    // closing request handed to the transmit side
    typedef struct packed {
        logic [7:0] channel;
        logic [7:0] mode;
        logic [15:0] length;
        logic no_rsp;
    } close_req_t;
endpackage

/* File: dv/host_rsp_sink.sv */
// host side of the response byte stream: takes bytes, may stall every other cycle
// assumes one clock; the bench reads the collected bytes and the reply count
`timescale 1ns/10ps
`default_nettype none
module host_rsp_sink (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // response stream
    input wire logic rsp_valid_in,
    input wire logic [7:0] rsp_byte_in,
    input wire logic rsp_last_in,
    output logic rsp_ready_out,
    // test control
    input wire logic stall_in
);
    logic [7:0] got[$];
    int frames = 0;
    initial rsp_ready_out = 1'b0;
    // keep taking bytes until the reply ends; ready moves just after the edge
    always @(posedge clk_in) begin
        if (rst_b_in && rsp_valid_in && rsp_ready_out) begin
            got.push_back(rsp_byte_in);
            if (rsp_last_in) frames++;
        end
        #1 rsp_ready_out <= stall_in ? !rsp_ready_out : 1'b1;
    end
endmodule
`default_nettype wire

/* File: dv/can_diag_session_commands_bench.sv */
// self-checking bench for the diagnostic session command block
// assumes channel 0 allocated, channel 1 not; short buffer and payload cap
`timescale 1ns/10ps
`default_nettype none
module can_diag_session_commands_bench;
    import can_diag_pkg::*;
    typedef logic [7:0] bq_t[$];
    logic clk_in = 0, rst_b_in = 0, cmd_valid_in = 0, fault_valid_in = 0, rx_valid_in = 0, stall = 0;
    logic cmd_ready_out, rsp_valid_out, rsp_last_out, rsp_ready, req_start_out;
    logic [7:0] rsp_byte_out, fault_code_in = 8'h00;
    logic [1:0] link_up_in = 2'b00, link_down_in = 2'b00;
    logic [1:0] chan_alloc = 2'b01;
    logic [7:0] diag_type = 8'h05, fault_chan = 8'h00;
    diag_cmd_t cmd_in = '0;
    rx_beat_t rx_in = '0;
    close_req_t req_out, last_req;
    int mismatches = 0, num_checks = 0, n_req = 0;
    always #12.5 clk_in = !clk_in;
    can_diag_session_commands #(.NCH(2), .DEPTH(8), .MAX_PARAM_BYTES(16'h000C)) i_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out),
        .rsp_last_out(rsp_last_out), .rsp_ready_in(rsp_ready), .chan_alloc_in(chan_alloc),
        .diag_type_in(diag_type), .link_up_in(link_up_in), .link_down_in(link_down_in),
        .fault_valid_in(fault_valid_in), .fault_chan_in(fault_chan), .fault_code_in(fault_code_in),
        .rx_valid_in(rx_valid_in), .rx_in(rx_in), .req_start_out(req_start_out), .req_out(req_out));
    host_rsp_sink i_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .rsp_valid_in(rsp_valid_out),
        .rsp_byte_in(rsp_byte_out), .rsp_last_in(rsp_last_out), .rsp_ready_out(rsp_ready), .stall_in(stall));
    // closing request pulses, counted with the fields they carried
    always @(posedge clk_in) if (req_start_out === 1'b1) begin
        n_req++;
        last_req = req_out;
    end
    task automatic compare(input logic [15:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask
    // hold the header until taken, then wait a bounded time for the whole reply
    task automatic run_cmd(input logic [7:0] code, ch, md, input logic [15:0] ln, input bq_t exp);
        int f;
        logic rdy;
        f = i_host.frames;
        i_host.got.delete();
        cmd_in <= '{code, ch, md, ln};
        cmd_valid_in <= 1'b1;
        do begin
            rdy = cmd_ready_out;
            tick();
        end while (rdy !== 1'b1);
        cmd_valid_in <= 1'b0;
        for (int i = 0; i < 200 && i_host.frames == f; i++) tick();
        compare(16'(i_host.frames - f), 16'h0001, "reply count");
        compare(16'(i_host.got.size()), 16'(exp.size()), "reply length");
        foreach (exp[i]) if (i < i_host.got.size()) compare({8'h00, i_host.got[i]}, {8'h00, exp[i]}, "reply byte");
    endtask
    task automatic put_fault(input logic [7:0] code);
        fault_code_in <= code;
        fault_valid_in <= 1'b1;
        tick();
        fault_valid_in <= 1'b0;
    endtask
    task automatic test_unalloc();
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        run_cmd(CMD_QUERY, 8'h01, 8'h00, 16'h0000, {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        run_cmd(CMD_STOP, 8'h01, 8'h00, 16'h0006, {8'h01, FAULT_NO_SESSION});
        compare(16'(n_req), 16'h0000, "request from unallocated stop");
        $display("test unalloc done");
    endtask
    task automatic test_start();
        put_fault(8'h33);
        run_cmd(CMD_START, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h33});
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h05, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00});
        link_up_in <= 2'b01;
        tick();
        link_up_in <= 2'b00;
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test start done");
    endtask
    task automatic test_stop();
        put_fault(8'h22);
        run_cmd(CMD_STOP, 8'h00, 8'h81, 16'h0006, {8'h00, 8'h22});
        compare(16'(n_req), 16'h0001, "closing request count");
        compare({15'h0000, last_req == close_req_t'{8'h00, 8'h81, 16'h0006, 1'b1}}, 16'h0001, "request fields");
        run_cmd(CMD_QUERY, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test stop done");
    endtask
    // six segmented bytes against a four byte payload cap, host stalling
    task automatic test_rx();
        stall = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rx_in <= '{8'h00, 8'(8'h62 + i), 1'b1, i == 5};
            rx_valid_in <= 1'b1;
            tick();
        end
        rx_valid_in <= 1'b0;
        run_cmd(CMD_QUERY, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h0D, 8'h04, 8'h04, 8'h00, 8'h02, 8'h00,
            8'h62, 8'h63, 8'h64, 8'h65});
        run_cmd(CMD_QUERY, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h05, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00,
            8'h66, 8'h67});
        run_cmd(CMD_QUERY, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        stall = 1'b0;
        $display("test rx done");
    endtask
    task automatic test_clear();
        link_down_in <= 2'b01;
        tick();
        link_down_in <= 2'b00;
        put_fault(8'h44);
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h44, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        run_cmd(CMD_STATE, 8'h00, CLEAR_FAULT, 16'h0000, {8'h00, 8'h44, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h00, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test clear done");
    endtask
    // stop without closing request keeps the fault and sends nothing
    task automatic test_stop0();
        int n;
        n = n_req;
        put_fault(8'h55);
        run_cmd(CMD_STOP, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h55});
        compare(16'(n_req - n), 16'h0000, "request on zero length");
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h55, 8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test stop0 done");
    endtask
    // channel 1 is allocated, stays not initialised and gets its own fault; then the type input drops to zero and the state query reports type zero
    task automatic test_shutdown();
        chan_alloc <= 2'b11;
        fault_chan <= 8'h01;
        put_fault(8'h66);
        run_cmd(CMD_STATE, 8'h01, 8'h00, 16'h0000, {8'h01, 8'h66, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h55, 8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        diag_type <= 8'h00;
        run_cmd(CMD_STATE, 8'h00, 8'h00, 16'h0000, {8'h00, 8'h55, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test shutdown done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clk_in);
        #1 rst_b_in <= 1'b1;
        tick();
        test_unalloc();
        test_start();
        test_stop();
        test_rx();
        test_clear();
        test_stop0();
        test_shutdown();
        complete_run();
    end
    // watchdog: all tests need well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
